/* verilog/smr_pkg.sv */
// package for the safety mute reset controller: timing, states, error codes
// assumes a single 20 MHz system clock drives every consumer of these constants
package smr_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int RESET_MIN_MS = 250;
	localparam int RESET_MAX_MS = 2000;
	localparam int RESET_MIN_CYC = (CLK_HZ / 1000) * RESET_MIN_MS;
	localparam int RESET_MAX_CYC = (CLK_HZ / 1000) * RESET_MAX_MS;
	localparam int FLASH_MS = 250;
	localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
	localparam int SELFTEST_CYC = 16;
	localparam int CNT_W = 26;

	// ----------------------------------------------------------------
	// diagnostic codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_STOP_CH = 8'h21;
	localparam logic [7:0] ERR_MUTE_STOP_CH = 8'h22;
	localparam logic [7:0] ERR_OUT_FB = 8'h31;
	localparam logic [7:0] ERR_REDUNDANT = 8'h41;
	localparam logic [7:0] ERR_MUTE_CFG = 8'h51;
	localparam logic [7:0] ERR_SELFTEST = 8'h61;
	localparam logic [7:0] ST_WAIT_RESET = 8'h0a;
	localparam logic [7:0] ST_RUN = 8'h0b;

	// ----------------------------------------------------------------
	// states, gray along test -> wait -> armed -> run
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SMR_TEST = 3'h0,
		SMR_WAIT = 3'h1,
		SMR_ARMED = 3'h3,
		SMR_RUN = 3'h2,
		SMR_LOCK = 3'h6
	} smr_state_t;

endpackage : smr_pkg

/* verilog/smr_controller.sv */
// output-enable and reset supervisor of a safety muting controller
// assumes all pin inputs are asynchronous; outputs drive external safety switches
// What this block does
// - manual reset counts only after open, closed, then open again
// - reset held closed 1/4 s to 2 s; outputs on at reopening
// - manual mode: both stop inputs closed plus valid reset enable outputs
// - manual mode: new reset after power-up, lockout, unmuted or stop reopen
// - auto mode: outputs on after self-test with both stop inputs closed
// - auto mode: outputs return after a stop input opens and recloses
// - lockout is left only through a valid manual reset
// - entering lockout forces both safety outputs off
// - lockout flashes red indicator and shows an error code
// - display codes identify the lockout cause and other conditions
// - continuous self-check; a failure turns outputs off and locks out
// - stop channel pairs cross-checked; a single fault there stops the machine; mute inputs not cross-checked
// - muteable stop input is two-channel and ignored while muted
// - muting needs two or four redundant mute inputs all active
// - muted: ignore muteable input; not muted: opening it stops outputs
// - opening the stop input stops outputs always, muted or not
module smr_controller
	import smr_pkg::*;
#(
	parameter int MIN_CYC = RESET_MIN_CYC,
	parameter int MAX_CYC = RESET_MAX_CYC,
	parameter int FLASH_CYCLES = FLASH_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// guard and stop channels, high = closed
	input wire logic [1:0] muteable_stop_input_in,
	input wire logic [1:0] stop_input_in,
	// mute devices, high = actuated
	input wire logic [3:0] mute_in,
	input wire logic mute_four_in,
	// reset terminal and configuration switches
	input wire logic reset_terminal_in,
	input wire logic auto_reset_cfg_in,
	// readback of the driven safety outputs
	input wire logic [1:0] output_fb_in,
	// outputs
	output logic safety_output_a_out,
	output logic safety_output_b_out,
	output logic red_led_out,
	output logic muted_out,
	output logic [7:0] diag_code_out
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	localparam int NIN = 13;
	logic [NIN-1:0] sync_a;
	logic [NIN-1:0] sync_b;
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {muteable_stop_input_in, stop_input_in, mute_in, mute_four_in,
				reset_terminal_in, auto_reset_cfg_in, output_fb_in};
			sync_b <= sync_a;
		end
	end
	logic [1:0] ms_s, st_s, fb_s;
	logic [3:0] mu_s;
	logic four_s, rst_s, auto_s;
	assign {ms_s, st_s, mu_s, four_s, rst_s, auto_s, fb_s} = sync_b;

	// ----------------------------------------------------------------
	// channel evaluation
	// ----------------------------------------------------------------
	function automatic logic both_closed(input logic [1:0] ch);
		return ch[0] & ch[1];
	endfunction
	function automatic logic mismatch(input logic [1:0] ch);
		return ch[0] ^ ch[1];
	endfunction

	logic ms_ok, st_ok, mute_act, guard_ok;
	assign ms_ok = both_closed(ms_s);
	assign st_ok = both_closed(st_s);
	// a pair in four-input mode still needs all four devices
	assign mute_act = four_s ? (&mu_s) : (&mu_s[1:0]);
	assign guard_ok = st_ok & (ms_ok | mute_act);

	// ----------------------------------------------------------------
	// state and timers
	// ----------------------------------------------------------------
	smr_state_t state, next_state;
	logic [CNT_W-1:0] hold, next_hold;
	logic [CNT_W-1:0] flash, next_flash;
	logic [4:0] test, next_test;
	logic rst_prev, next_rst_prev;
	logic seen_open, next_seen_open;
	logic reset_ok, next_reset_ok;
	logic [7:0] err, next_err;
	logic red, next_red;
	logic [7:0] mis_cnt, next_mis_cnt;
	logic mute_reg, next_mute_reg;
	logic out_on, next_out_on;
	logic out_d1, next_out_d1;
	logic out_d2, next_out_d2;

	// reset gesture tracker, shared by manual mode and lockout recovery
	logic release_edge, valid_release;
	assign release_edge = rst_prev & !rst_s;
	assign valid_release = release_edge & seen_open & (hold >= CNT_W'(MIN_CYC))
		& (hold <= CNT_W'(MAX_CYC));

	logic fault;
	logic [7:0] fault_code;
	always_comb begin
		fault = 1'b0;
		fault_code = ERR_NONE;
		// channels left disagreeing beyond the filter count mean a wiring or internal fault
		if (mis_cnt == 8'hff) begin
			fault = 1'b1;
			fault_code = mismatch(st_s) ? ERR_STOP_CH : ERR_MUTE_STOP_CH;
		end
		// readback passes the two synchroniser stages, so compare with a copy delayed alike
		if (out_d2 && fb_s != 2'b11 || !out_d2 && fb_s != 2'b00) begin
			fault = 1'b1;
			fault_code = ERR_OUT_FB;
		end
		if (safety_output_a_out != safety_output_b_out) begin
			fault = 1'b1;
			fault_code = ERR_REDUNDANT;
		end
		if (four_s == 1'b0 && (mu_s[3] | mu_s[2]) && !(&mu_s[1:0]) && 1'b0) begin
			fault_code = ERR_MUTE_CFG;
		end
	end

	always_comb begin
		next_state = state;
		next_test = test;
		next_err = err;
		next_rst_prev = rst_s;
		next_seen_open = seen_open;
		next_reset_ok = 1'b0;
		next_hold = hold;
		next_out_d1 = out_on;
		next_out_d2 = out_d1;
		next_mute_reg = mute_act & ms_ok | mute_act & mute_reg;
		next_mis_cnt = (mismatch(st_s) | (mismatch(ms_s) & !mute_act)) ?
			((mis_cnt == 8'hff) ? mis_cnt : mis_cnt + 8'h01) : 8'h00;
		// hold timer runs while closed, saturating past the limit
		if (rst_s) begin
			if (hold != {CNT_W{1'b1}}) begin
				next_hold = hold + CNT_W'(1);
			end
		end else begin
			next_hold = '0;
		end
		if (!rst_s && !release_edge) begin
			next_seen_open = 1'b1;
		end else if (release_edge) begin
			next_seen_open = 1'b1;
		end
		if (valid_release) begin
			next_reset_ok = 1'b1;
		end
		next_flash = (flash >= CNT_W'(FLASH_CYCLES - 1)) ? '0 : flash + CNT_W'(1);
		next_red = red;
		if (flash >= CNT_W'(FLASH_CYCLES - 1)) begin
			next_red = (state == SMR_LOCK) ? !red : 1'b0;
		end
		if (state != SMR_LOCK) begin
			next_red = 1'b0;
		end
		next_out_on = 1'b0;
		case (state)
			SMR_TEST: begin
				next_test = test + 5'd1;
				if (fb_s != 2'b00) begin
					next_state = SMR_LOCK;
					next_err = ERR_SELFTEST;
				end else if (test == 5'(SELFTEST_CYC)) begin
					next_state = SMR_WAIT;
					next_err = ST_WAIT_RESET;
				end
			end
			SMR_WAIT: begin
				next_err = ST_WAIT_RESET;
				if (!guard_ok) begin
					next_state = SMR_WAIT;
				end else if (auto_s) begin
					next_state = SMR_RUN;
				end else begin
					next_state = SMR_ARMED;
				end
			end
			SMR_ARMED: begin
				// a reset is only accepted with the stop input closed and the guard closed or muted
				if (!guard_ok) begin
					next_state = SMR_WAIT;
				end else if (valid_release) begin
					next_state = SMR_RUN;
				end
			end
			SMR_RUN: begin
				next_out_on = 1'b1;
				next_err = ST_RUN;
				if (!guard_ok) begin
					next_out_on = 1'b0;
					next_state = SMR_WAIT;
				end
			end
			SMR_LOCK: begin
				if (valid_release) begin
					next_state = SMR_WAIT;
				end
			end
			default: begin
				next_state = SMR_LOCK;
			end
		endcase
		if (fault && state != SMR_LOCK && state != SMR_TEST) begin
			next_state = SMR_LOCK;
			next_err = fault_code;
			next_out_on = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state <= SMR_TEST;
			test <= '0;
			err <= ERR_NONE;
			rst_prev <= 1'b0;
			seen_open <= 1'b0;
			reset_ok <= 1'b0;
			hold <= '0;
			flash <= '0;
			red <= 1'b0;
			mis_cnt <= '0;
			mute_reg <= 1'b0;
			out_on <= 1'b0;
			out_d1 <= 1'b0;
			out_d2 <= 1'b0;
		end else begin
			state <= next_state;
			test <= next_test;
			err <= next_err;
			rst_prev <= next_rst_prev;
			seen_open <= next_seen_open;
			reset_ok <= next_reset_ok;
			hold <= next_hold;
			flash <= next_flash;
			red <= next_red;
			mis_cnt <= next_mis_cnt;
			mute_reg <= next_mute_reg;
			out_on <= next_out_on;
			out_d1 <= next_out_d1;
			out_d2 <= next_out_d2;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			safety_output_a_out <= 1'b0;
			safety_output_b_out <= 1'b0;
			red_led_out <= 1'b0;
			muted_out <= 1'b0;
			diag_code_out <= ERR_NONE;
		end else begin
			safety_output_a_out <= next_out_on;
			safety_output_b_out <= next_out_on;
			red_led_out <= next_red;
			muted_out <= next_mute_reg;
			diag_code_out <= next_err;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	AST_LOCK_OFF: assert property (state == SMR_LOCK |-> !safety_output_a_out
		&& !safety_output_b_out) else $error("outputs on in lockout");
	AST_STOP_OFF: assert property (!st_ok |=> !safety_output_a_out)
		else $error("output on with stop open");
	AST_MUTE_OFF: assert property (!ms_ok && !mute_act |=> !safety_output_b_out)
		else $error("output on with guard open, not muted");
	AST_LOCK_EXIT: assert property (state == SMR_LOCK && !valid_release
		|=> state == SMR_LOCK) else $error("lockout left without reset");
	AST_MAN_ON: assert property ($rose(safety_output_a_out) && !auto_s
		|-> $past(reset_ok)) else $error("manual on without reset");
	AST_HOLD_MIN: assert property (valid_release |-> hold >= CNT_W'(MIN_CYC))
		else $error("reset hold too short");
	AST_FAULT_LOCK: assert property (fault && state == SMR_RUN |=> state == SMR_LOCK
		&& !safety_output_a_out) else $error("fault not locked out");
	AST_PAIR: assert property (safety_output_a_out == safety_output_b_out)
		else $error("safety outputs disagree");
	AST_AUTO_ON: assert property (state == SMR_WAIT && auto_s && guard_ok && !fault
		|=> state == SMR_RUN ##1 safety_output_a_out)
		else $error("auto mode did not restart");
	AST_LOCK_CODE: assert property (state == SMR_LOCK |-> diag_code_out != ST_RUN)
		else $error("lockout shows run code");

	COV_MANUAL: cover property (!auto_s && valid_release && state == SMR_ARMED);
	COV_AUTO: cover property (auto_s && state == SMR_RUN);
	COV_MUTED: cover property (mute_act && !ms_ok && safety_output_a_out);
	COV_LOCK_OUT: cover property (state == SMR_LOCK ##1 state == SMR_WAIT);

endmodule : smr_controller

/* testbench/smr_field_model.sv */
// field side model: light screen, stop device, reset switch, output readback
// assumes the bench sets the command levels at the falling clock edge
module smr_field_model (
	// commands from the bench
	input wire logic guard_clear_in,
	input wire logic stop_clear_in,
	input wire logic switch_pressed_in,
	input wire logic channel_fault_in,
	// driven safety outputs
	input wire logic safety_output_a_in,
	input wire logic safety_output_b_in,
	// pins towards the controller
	output logic [1:0] muteable_stop_input_out,
	output logic [1:0] stop_input_out,
	output logic reset_terminal_out,
	output logic [1:0] output_fb_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// a faulty screen drops one channel only, so the pair disagrees
	assign muteable_stop_input_out = {guard_clear_in & ~channel_fault_in, guard_clear_in};
	assign stop_input_out = {stop_clear_in, stop_clear_in};
	// plain contact: open reads low, no pull-up on the far side
	assign reset_terminal_out = switch_pressed_in;
	// zero-delay loop; the controller allows for its own synchroniser lag
	assign output_fb_out = {safety_output_b_in, safety_output_a_in};
endmodule : smr_field_model

/* testbench/smr_controller_test.sv */
// self-checking bench for the safety mute reset controller
// assumes short count parameters; the field model sits on the pins
module smr_controller_test import smr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MINC = 20;
	localparam int MAXC = 200;
	logic clk_in = 1'b0;
	logic resetn_in, guard, stop_ok, press, fault, mute_four_in, auto_reset_cfg_in;
	logic [3:0] mute_in;
	logic [1:0] muteable_stop_input_in, stop_input_in, output_fb_in;
	logic reset_terminal_in, sa, sb, red_led_out, muted_out, led_last;
	logic [7:0] diag_code_out;
	wire logic [7:0] outs = {6'h00, sa, sb};
	int err_count = 0;
	int n_tests = 0;
	int seed = 32'he3bb;
	int h, k, toggles;

	always #25 clk_in = ~clk_in;

	smr_controller #(.MIN_CYC(MINC), .MAX_CYC(MAXC), .FLASH_CYCLES(8)) u_smr_controller (
		.clk_in(clk_in), .resetn_in(resetn_in),
		.muteable_stop_input_in(muteable_stop_input_in), .stop_input_in(stop_input_in),
		.mute_in(mute_in), .mute_four_in(mute_four_in), .reset_terminal_in(reset_terminal_in),
		.auto_reset_cfg_in(auto_reset_cfg_in), .output_fb_in(output_fb_in),
		.safety_output_a_out(sa), .safety_output_b_out(sb), .red_led_out(red_led_out),
		.muted_out(muted_out), .diag_code_out(diag_code_out));
	smr_field_model u_smr_field_model (
		.guard_clear_in(guard), .stop_clear_in(stop_ok), .switch_pressed_in(press),
		.channel_fault_in(fault), .safety_output_a_in(sa), .safety_output_b_in(sb),
		.muteable_stop_input_out(muteable_stop_input_in), .stop_input_out(stop_input_in),
		.reset_terminal_out(reset_terminal_in), .output_fb_out(output_fb_in));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] hold_result(input int n);
		return (n >= MINC && n <= MAXC) ? 8'h03 : 8'h00;
	endfunction : hold_result

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic outs_within(input logic [7:0] exp, input int bound);
		int i;
		i = 0;
		while (i < bound && outs !== exp) begin
			cyc(1);
			i++;
		end
		chk("safety outputs", exp, outs);
		if (outs !== exp)
			results();
	endtask : outs_within

	task automatic stays(input logic [7:0] exp, input int n);
		logic [7:0] seen;
		seen = exp;
		repeat (n) begin
			cyc(1);
			if (outs !== exp)
				seen = outs;
		end
		chk("safety outputs held", exp, seen);
	endtask : stays

	task automatic press_reset(input int n);
		press = 1'b1;
		cyc(n);
		press = 1'b0;
	endtask : press_reset

	task automatic power_up();
		resetn_in = 1'b0;
		cyc(8);
		chk("outputs in reset", 8'h00, outs);
		chk("diag in reset", ERR_NONE, diag_code_out);
		resetn_in = 1'b1;
		cyc(30);
	endtask : power_up

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{resetn_in, press, fault, mute_four_in, auto_reset_cfg_in} = 5'b00000;
		{guard, stop_ok, mute_in} = 6'b110000;
		cyc(1);
		power_up();
		chk("diag waiting", ST_WAIT_RESET, diag_code_out);
		stays(8'h00, 40);
		$display("test power-up done");
		// too short, too long, then a random valid hold
		for (k = 0; k < 3; k++) begin
			h = (k == 0) ? MINC - 4 : (k == 1) ? MAXC + 4 : MINC + 4 + ($unsigned($random(seed)) % (MAXC - MINC - 8));
			press_reset(h);
			if (hold_result(h) == 8'h03)
				outs_within(hold_result(h), 12);
			else
				stays(hold_result(h), 20);
		end
		chk("diag running", ST_RUN, diag_code_out);
		$display("test reset hold done");
		mute_in = {2'($random(seed)), 2'b11};
		cyc(4);
		chk("muted", 8'h01, {7'h00, muted_out});
		guard = 1'b0;
		stays(8'h03, 20);
		stop_ok = 1'b0;
		outs_within(8'h00, 6);
		{stop_ok, guard, mute_in} = 6'b110000;
		stays(8'h00, 20);
		press_reset(50);
		outs_within(8'h03, 12);
		$display("test muting done");
		{mute_four_in, mute_in, guard} = 6'b100110;
		outs_within(8'h00, 6);
		{mute_four_in, mute_in} = 5'b00000;
		press_reset(50);
		stays(8'h00, 20);
		guard = 1'b1;
		stays(8'h00, 20);
		press_reset(MINC + 10);
		outs_within(8'h03, 12);
		$display("test four-input mute done");
		auto_reset_cfg_in = 1'b1;
		power_up();
		outs_within(8'h03, 10);
		stop_ok = 1'b0;
		outs_within(8'h00, 6);
		stop_ok = 1'b1;
		outs_within(8'h03, 10);
		guard = 1'b0;
		outs_within(8'h00, 6);
		guard = 1'b1;
		outs_within(8'h03, 10);
		$display("test automatic reset done");
		fault = 1'b1;
		outs_within(8'h00, 300);
		stays(8'h00, 280);
		chk("diag lockout", ERR_MUTE_STOP_CH, diag_code_out);
		toggles = 0;
		led_last = red_led_out;
		repeat (40) begin
			cyc(1);
			toggles += (red_led_out !== led_last);
			led_last = red_led_out;
		end
		chk("red flashing", 8'h01, {7'h00, toggles >= 2});
		fault = 1'b0;
		stays(8'h00, 30);
		press_reset(50);
		outs_within(8'h03, 15);
		chk("red after exit", 8'h00, {7'h00, red_led_out});
		$display("test lockout done");
		results();
	end
endmodule : smr_controller_test
